// [hdl/iex_ext_chan.sv]
// one external interrupt channel: pin select, edge detect and timestamp counter
`timescale 1ns/1ps
`default_nettype none
module iex_ext_chan
    import iex_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] pin_bus,
    input  wire logic [4:0]  pin_sel,
    input  wire logic [1:0]  edge_mode,
    input  wire logic        chan_en,
    output logic             edge_evt,
    output logic [15:0]      stamp
);
    logic        prev_reg,   prev_next;
    logic        primed_reg, primed_next;
    logic        evt_reg,    evt_next;
    logic [15:0] cnt_reg,    cnt_next;
    logic        pin_now;
    logic        rise;
    logic        fall;
    logic        hit;

    // edge qualification and counter next state
    always_comb begin
        pin_now     = pin_bus[pin_sel];
        rise        = primed_reg & pin_now & ~prev_reg;
        fall        = primed_reg & ~pin_now & prev_reg;
        case (edge_mode)
            IEX_EDGE_FALL: hit = fall;
            IEX_EDGE_RISE: hit = rise;
            default:       hit = rise | fall;
        endcase
        prev_next   = pin_now;
        primed_next = 1'b1;
        evt_next    = hit & chan_en;
        cnt_next    = hit ? IEX_STAMP_RST : cnt_reg + 16'h0001;
    end

    // registers, synchronous active-low reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prev_reg   <= 1'b0;
            primed_reg <= 1'b0;
            evt_reg    <= 1'b0;
            cnt_reg    <= IEX_STAMP_RST;
        end else begin
            prev_reg   <= prev_next;
            primed_reg <= primed_next;
            evt_reg    <= evt_next;
            cnt_reg    <= cnt_next;
        end
    end

    assign edge_evt = evt_reg;
    assign stamp    = cnt_reg;
endmodule
`default_nettype wire

// [hdl/iex_irq_top.sv]
// interrupt expansion block with three external interrupt channels
// What this block does
// - gathers up to 96 peripheral interrupt sources onto fewer cpu lines
// - only 43 source slots are wired; the rest never raise requests
// - sources form groups of eight, each group drives one of twelve lines
// - every slot owns a software-writable vector in a dedicated ram
// - an acknowledged interrupt delivers its vector after eight clock cycles
// - each source slot has its own enable bit
// - fixed lowest-slot-first priority inside a group; software uses enables
// - three external channels: two general, one nonmaskable-capable
// - the nonmaskable-capable channel goes to line thirteen or the nmi input
// - each channel triggers on falling, rising or both edges
// - each channel has an enable gating its interrupt
// - each channel has a 16-bit up counter cleared by a valid edge
// - the channel counters are readable as timestamps
// - any port a pin can be chosen as any channel's source
`timescale 1ns/1ps
`default_nettype none
module iex_irq_top
    import iex_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // peripheral requests, one per slot
    input  wire logic [95:0] periph_irq,
    // port a pins and external channel setup
    input  wire logic [31:0] gpio_port_a,
    input  wire logic [4:0]  ext1_pin_sel,
    input  wire logic [4:0]  ext2_pin_sel,
    input  wire logic [4:0]  nmi_pin_sel,
    input  wire logic [1:0]  ext1_edge_mode,
    input  wire logic [1:0]  ext2_edge_mode,
    input  wire logic [1:0]  nmi_edge_mode,
    input  wire logic        ext1_en,
    input  wire logic        ext2_en,
    input  wire logic        nmi_chan_en,
    input  wire logic        nmi_route_nmi,
    // enable writes and pending readback, one group at a time
    input  wire logic        en_wr,
    input  wire logic [3:0]  en_grp,
    input  wire logic [7:0]  en_wdata,
    // vector ram port
    input  wire logic        vec_wr,
    input  wire logic        vec_rd,
    input  wire logic [6:0]  vec_addr,
    input  wire logic [21:0] vec_wdata,
    // cpu acknowledge
    input  wire logic        cpu_ack,
    input  wire logic [3:0]  cpu_ack_line,
    input  wire logic        cpu_ack13,
    input  wire logic        cpu_nmi_ack,
    // outputs
    output logic [11:0]      cpu_irq_line,
    output logic             cpu_irq_line_thirteenth,
    output logic             cpu_nmi,
    output logic             vec_valid,
    output logic [21:0]      vec_out,
    output logic [6:0]       vec_slot,
    output logic [21:0]      vec_rdata,
    output logic [7:0]       en_rdata,
    output logic [7:0]       pend_rdata,
    output logic [15:0]      ext1_stamp,
    output logic [15:0]      ext2_stamp,
    output logic [15:0]      nmi_stamp
);
    // one vector per slot, no reset: software fills a slot before enabling it
    logic [21:0] vec_mem [IEX_NUM_SRC];
    logic [7:0]  en_reg [IEX_NUM_GRP];
    logic [7:0]  en_next [IEX_NUM_GRP];
    logic [95:0] pend_reg,   pend_next;
    logic [11:0] line_reg,   line_next;
    logic        l13_reg,    l13_next;
    logic        nmi_reg,    nmi_next;
    iex_state_t  state_reg,  state_next;
    logic [3:0]  cnt_reg,    cnt_next;
    logic [6:0]  slot_reg,   slot_next;
    logic        vval_reg,   vval_next;
    logic [21:0] vout_reg,   vout_next;
    logic [21:0] vrd_reg,    vrd_next;
    logic [7:0]  enrd_reg,   enrd_next;
    logic [7:0]  pdrd_reg,   pdrd_next;
    logic [95:0] src_set;
    logic [95:0] src_clr;
    logic [95:0] en_flat;
    logic        ext1_evt;
    logic        ext2_evt;
    logic        nmi_evt;
    logic        ack_take;
    logic [6:0]  pick;
    logic [3:0]  g_idx;
    logic [7:0]  g_hit;
    logic [2:0]  pick_lo;

    // external channels
    // all three channels watch the same port a pins, each through its own selector
    iex_ext_chan u_ext1 (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .pin_bus   (gpio_port_a),
        .pin_sel   (ext1_pin_sel),
        .edge_mode (ext1_edge_mode),
        .chan_en   (ext1_en),
        .edge_evt  (ext1_evt),
        .stamp     (ext1_stamp)
    );
    iex_ext_chan u_ext2 (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .pin_bus   (gpio_port_a),
        .pin_sel   (ext2_pin_sel),
        .edge_mode (ext2_edge_mode),
        .chan_en   (ext2_en),
        .edge_evt  (ext2_evt),
        .stamp     (ext2_stamp)
    );
    iex_ext_chan u_nmi (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .pin_bus   (gpio_port_a),
        .pin_sel   (nmi_pin_sel),
        .edge_mode (nmi_edge_mode),
        .chan_en   (nmi_chan_en),
        .edge_evt  (nmi_evt),
        .stamp     (nmi_stamp)
    );

    // fixed-priority pick within the acknowledged group
    // an acknowledge of a group with nothing pending still fetches its slot 0 vector
    always_comb begin
        ack_take = cpu_ack & (state_reg == IEX_IDLE) & (cpu_ack_line < 4'd12);
        g_idx    = cpu_ack_line;
        for (int g = 0; g < IEX_NUM_GRP; g++) begin
            en_flat[g*8 +: 8] = en_reg[g];
        end
        g_hit    = 8'h00;
        if (cpu_ack_line < 4'd12) begin
            g_hit = pend_reg[cpu_ack_line*8 +: 8] & en_reg[cpu_ack_line];
        end
        pick_lo  = 3'd0;
        for (int i = 7; i >= 0; i--) begin
            if (g_hit[i]) begin
                pick_lo = 3'(i);
            end
        end
        pick     = {g_idx[3:0], pick_lo};
    end

    // pending flags: a new request wins over the acknowledge clear
    always_comb begin
        src_set = periph_irq;
        src_set[IEX_SLOT_EXT1] = periph_irq[IEX_SLOT_EXT1] | ext1_evt;
        src_set[IEX_SLOT_EXT2] = periph_irq[IEX_SLOT_EXT2] | ext2_evt;
        // slots that no peripheral uses are masked so stray inputs cannot pend
        src_set = src_set & IEX_USED_MASK;
        src_clr = 96'h0000_0000_0000_0000_0000_0000;
        if (ack_take && g_hit != 8'h00) begin
            src_clr[pick] = 1'b1;
        end
        pend_next = (pend_reg & ~src_clr) | src_set;
    end

    // enable writes, one group of eight per write; groups above eleven are ignored
    always_comb begin
        for (int g = 0; g < IEX_NUM_GRP; g++) begin
            en_next[g] = en_reg[g];
        end
        if (en_wr && en_grp < 4'd12) begin
            en_next[en_grp] = en_wdata;
        end
    end

    // readback values, presented one cycle after the request
    always_comb begin
        vrd_next  = vrd_reg;
        // reads past the last slot leave the readback as it was
        if (vec_rd && vec_addr < 7'd96) begin
            vrd_next = vec_mem[vec_addr];
        end
        enrd_next = (en_grp < 4'd12) ? en_reg[en_grp] : 8'h00;
        pdrd_next = (en_grp < 4'd12) ? pend_reg[en_grp*8 +: 8] : 8'h00;
    end

    // cpu lines: or of enabled pending sources per group
    // line thirteen and nmi stay set until acknowledged; a new event beats the clear
    always_comb begin
        for (int g = 0; g < IEX_NUM_GRP; g++) begin
            line_next[g] = |(pend_reg[g*8 +: 8] & en_flat[g*8 +: 8]);
        end
        l13_next = (l13_reg & ~cpu_ack13) | (nmi_evt & ~nmi_route_nmi);
        nmi_next = (nmi_reg & ~cpu_nmi_ack) | (nmi_evt & nmi_route_nmi);
    end

    // vector fetch sequence
    // the count starts at the taking edge, so the vector shows eight cycles later
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        slot_next  = slot_reg;
        vval_next  = 1'b0;
        vout_next  = vout_reg;
        case (state_reg)
            IEX_IDLE: begin
                if (ack_take) begin
                    slot_next  = pick;
                    cnt_next   = 4'd1;
                    state_next = IEX_FETCH;
                end
            end
            IEX_FETCH: begin
                cnt_next = cnt_reg + 4'd1;
                if (cnt_reg == 4'(IEX_FETCH_CYC - 1)) begin
                    vout_next  = vec_mem[slot_reg];
                    vval_next  = 1'b1;
                    state_next = IEX_DONE;
                end
            end
            IEX_DONE: begin
                state_next = IEX_IDLE;
            end
            default: begin
                state_next = IEX_IDLE;
            end
        endcase
    end

    // vector ram, not reset, writable by software; writes past the last slot are dropped
    always_ff @(posedge sys_clk) begin
        if (vec_wr && vec_addr < 7'd96) begin
            vec_mem[vec_addr] <= vec_wdata;
        end
    end

    // readback registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            vrd_reg  <= IEX_VEC_RST;
            enrd_reg <= 8'h00;
            pdrd_reg <= 8'h00;
        end else begin
            vrd_reg  <= vrd_next;
            enrd_reg <= enrd_next;
            pdrd_reg <= pdrd_next;
        end
    end

    // enable registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int g = 0; g < IEX_NUM_GRP; g++) begin
                en_reg[g] <= IEX_EN_RST;
            end
        end else begin
            for (int g = 0; g < IEX_NUM_GRP; g++) begin
                en_reg[g] <= en_next[g];
            end
        end
    end

    // pending flags and cpu line registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pend_reg <= 96'h0000_0000_0000_0000_0000_0000;
            line_reg <= 12'h000;
            l13_reg  <= 1'b0;
            nmi_reg  <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            line_reg <= line_next;
            l13_reg  <= l13_next;
            nmi_reg  <= nmi_next;
        end
    end

    // fetch engine registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_reg <= IEX_IDLE;
            cnt_reg   <= 4'h0;
            slot_reg  <= 7'h00;
            vval_reg  <= 1'b0;
            vout_reg  <= IEX_VEC_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            slot_reg  <= slot_next;
            vval_reg  <= vval_next;
            vout_reg  <= vout_next;
        end
    end

    // outputs straight from flip-flops
    assign cpu_irq_line            = line_reg;
    assign cpu_irq_line_thirteenth = l13_reg;
    assign cpu_nmi                 = nmi_reg;
    assign vec_valid               = vval_reg;
    assign vec_out                 = vout_reg;
    assign vec_slot                = slot_reg;
    assign vec_rdata               = vrd_reg;
    assign en_rdata                = enrd_reg;
    assign pend_rdata              = pdrd_reg;
endmodule
`default_nettype wire

// [hdl/iex_pkg.sv]
// constants shared by the interrupt expansion block and its external channels
package iex_pkg;
    localparam int          IEX_NUM_SRC    = 96;           // source slots in the expansion block
    localparam int          IEX_NUM_GRP    = 12;           // cpu interrupt lines fed by groups
    localparam int          IEX_GRP_SIZE   = 8;            // sources per group
    localparam int          IEX_NUM_USED   = 43;           // slots wired to peripherals
    localparam int          IEX_VEC_W      = 22;           // vector width, program address
    localparam int          IEX_STAMP_W    = 16;           // timestamp counter width
    localparam int          IEX_PIN_W      = 32;           // port a gpio pins
    localparam int          IEX_FETCH_CYC  = 8;            // vector fetch plus context save
    localparam logic [6:0]  IEX_SLOT_EXT1  = 7'h03;        // slot taken by external channel one
    localparam logic [6:0]  IEX_SLOT_EXT2  = 7'h04;        // slot taken by external channel two
    localparam logic [95:0] IEX_USED_MASK  = 96'h0000_0000_0000_07FF_FFFF_FFFF;
    localparam logic [7:0]  IEX_EN_RST     = 8'h00;        // enables after reset
    localparam logic [21:0] IEX_VEC_RST    = 22'h00_0000;  // vector readback after reset
    localparam logic [15:0] IEX_STAMP_RST  = 16'h0000;     // counter after reset
    // edge selection codes
    localparam logic [1:0]  IEX_EDGE_FALL  = 2'b00;
    localparam logic [1:0]  IEX_EDGE_RISE  = 2'b01;
    typedef enum logic [1:0] {IEX_IDLE, IEX_FETCH, IEX_DONE} iex_state_t;
endpackage

// [sim/iex_cpu_model.sv]
// processor side model acknowledging group lines, line thirteen and nmi
`timescale 1ns/1ps
`default_nettype none
module iex_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        auto_ack,
    input  wire logic [11:0] cpu_irq_line,
    input  wire logic        cpu_irq_line_thirteenth,
    input  wire logic        cpu_nmi,
    output var logic         cpu_ack = 1'b0,
    output var logic [3:0]   cpu_ack_line = 4'h0,
    output var logic         cpu_ack13 = 1'b0,
    output var logic         cpu_nmi_ack = 1'b0
);
    int gap = 0;
    // lowest numbered active line is served first
    function automatic logic [3:0] low_line(input logic [11:0] l);
        low_line = 4'h0;
        for (int i = 11; i >= 0; i--) if (l[i]) low_line = 4'(i);
    endfunction
    // one-cycle acknowledge pulses, spaced so the fetch engine is idle
    always @(negedge sys_clk) begin
        cpu_ack     <= 1'b0;
        cpu_ack13   <= auto_ack && cpu_irq_line_thirteenth && !cpu_ack13;
        cpu_nmi_ack <= auto_ack && cpu_nmi && !cpu_nmi_ack;
        if (gap > 0) gap <= gap - 1;
        else if (auto_ack && cpu_irq_line != 12'h000) begin
            cpu_ack      <= 1'b1;
            cpu_ack_line <= low_line(cpu_irq_line);
            gap          <= 10;
        end
    end
endmodule
`default_nettype wire

// [sim/iex_irq_top_asserts.sv]
// port checks for the interrupt expansion block
`timescale 1ns/1ps
`default_nettype none
module iex_irq_top_asserts
    import iex_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        nmi_chan_en,
    input wire logic        nmi_route_nmi,
    input wire logic        cpu_ack,
    input wire logic [3:0]  cpu_ack_line,
    input wire logic        cpu_ack13,
    input wire logic        cpu_nmi_ack,
    input wire logic [11:0] cpu_irq_line,
    input wire logic        cpu_irq_line_thirteenth,
    input wire logic        cpu_nmi,
    input wire logic        vec_valid,
    input wire logic [6:0]  vec_slot,
    input wire logic [15:0] ext1_stamp,
    input wire logic [15:0] nmi_stamp
);
    logic [3:0] busy_reg;
    logic [3:0] busy_next;
    logic       take;
    // an acknowledge counts only while the fetch engine is idle
    always_comb begin
        take      = cpu_ack && busy_reg == 4'h0 && cpu_ack_line < 4'hc;
        busy_next = take ? 4'h8 : busy_reg - 4'(busy_reg != 4'h0);
    end
    always_ff @(posedge sys_clk) begin
        busy_reg <= rst_b ? busy_next : 4'h0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // seven quiet cycles, one valid cycle, then quiet again
    sequence s_fetch;
        !vec_valid [*7] ##1 vec_valid ##1 !vec_valid;
    endsequence
    a_fetch_time: assert property (take |=> s_fetch)
        else $error("vector not delivered on time");
    a_valid_cause: assert property (vec_valid |-> $past(take, 8))
        else $error("vector valid without acknowledge");
    a_slot_group: assert property (vec_valid |-> vec_slot[6:3] == $past(cpu_ack_line, 8))
        else $error("vector slot outside acknowledged group");
    // the enable gates the channel event one cycle before the routing is applied
    a_nmi_route: assert property ($rose(cpu_nmi) |->
        $past(nmi_route_nmi) && $past(nmi_chan_en, 2))
        else $error("nmi raised against routing or enable");
    a_line13_route: assert property ($rose(cpu_irq_line_thirteenth) |->
        !$past(nmi_route_nmi) && $past(nmi_chan_en, 2))
        else $error("line thirteen raised against routing or enable");
    a_line13_clear: assert property ($fell(cpu_irq_line_thirteenth) |-> $past(cpu_ack13))
        else $error("line thirteen dropped without acknowledge");
    a_nmi_clear: assert property ($fell(cpu_nmi) |-> $past(cpu_nmi_ack))
        else $error("nmi dropped without acknowledge");
    a_stamp_run: assert property (ext1_stamp != 16'h0000 |->
        ext1_stamp == $past(ext1_stamp) + 16'h0001)
        else $error("channel one counter skipped");
    a_nmi_stamp: assert property (nmi_stamp != 16'h0000 |->
        nmi_stamp == $past(nmi_stamp) + 16'h0001)
        else $error("nmi channel counter skipped");
    a_reset_quiet: assert property (disable iff (1'b0) rst_b && $past(!rst_b) |->
        cpu_irq_line == 12'h000 && !vec_valid && !cpu_nmi)
        else $error("outputs active after reset");
endmodule
bind iex_irq_top iex_irq_top_asserts i_iex_irq_top_asserts (.sys_clk, .rst_b, .nmi_chan_en,
    .nmi_route_nmi, .cpu_ack, .cpu_ack_line, .cpu_ack13, .cpu_nmi_ack, .cpu_irq_line,
    .cpu_irq_line_thirteenth, .cpu_nmi, .vec_valid, .vec_slot, .ext1_stamp, .nmi_stamp);
`default_nettype wire

// [sim/test_iex_irq_top.sv]
// testbench for the interrupt expansion block and its external channels
`timescale 1ns/1ps
`default_nettype none
module test_iex_irq_top;
    import iex_pkg::*;
    logic        sys_clk = 0, rst_b = 0, auto_ack = 0, en_wr = 0, vec_wr = 0, vec_rd = 0;
    logic        ext1_en = 0, ext2_en = 0, nmi_chan_en = 0, nmi_route_nmi = 0;
    logic [95:0] periph_irq = '0;
    logic [31:0] gpio_port_a = '0;
    logic [4:0]  ext1_pin_sel = '0, ext2_pin_sel = '0, nmi_pin_sel = '0;
    logic [1:0]  ext1_edge_mode = '0, ext2_edge_mode = '0, nmi_edge_mode = '0;
    logic [3:0]  en_grp = '0, cpu_ack_line;
    logic [7:0]  en_wdata = '0, en_rdata, pend_rdata;
    logic [6:0]  vec_addr = '0, vec_slot;
    logic [21:0] vec_wdata = '0, vec_out, vec_rdata;
    logic [11:0] cpu_irq_line;
    logic [15:0] ext1_stamp, ext2_stamp, nmi_stamp;
    logic        cpu_ack, cpu_ack13, cpu_nmi_ack, cpu_irq_line_thirteenth, cpu_nmi, vec_valid;
    int          fails = 0, checks = 0;
    iex_irq_top i_iex_irq_top (.sys_clk, .rst_b, .periph_irq, .gpio_port_a, .ext1_pin_sel,
        .ext2_pin_sel, .nmi_pin_sel, .ext1_edge_mode, .ext2_edge_mode, .nmi_edge_mode,
        .ext1_en, .ext2_en, .nmi_chan_en, .nmi_route_nmi, .en_wr, .en_grp, .en_wdata,
        .vec_wr, .vec_rd, .vec_addr, .vec_wdata, .cpu_ack, .cpu_ack_line, .cpu_ack13,
        .cpu_nmi_ack, .cpu_irq_line, .cpu_irq_line_thirteenth, .cpu_nmi, .vec_valid,
        .vec_out, .vec_slot, .vec_rdata, .en_rdata, .pend_rdata, .ext1_stamp, .ext2_stamp,
        .nmi_stamp);
    iex_cpu_model i_iex_cpu_model (.sys_clk, .auto_ack, .cpu_irq_line,
        .cpu_irq_line_thirteenth, .cpu_nmi, .cpu_ack, .cpu_ack_line, .cpu_ack13, .cpu_nmi_ack);
    always #5 sys_clk = ~sys_clk;
    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic do_reset;
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
    endtask
    task automatic en_set(input logic [3:0] g, input logic [7:0] d);
        en_grp = g;
        en_wdata = d;
        en_wr = 1'b1;
        cyc(1);
        en_wr = 1'b0;
        cyc(1);
    endtask
    // enabled, disabled and unwired slots against the group lines
    task automatic t_lines;
        for (int g = 0; g < 7; g++) begin
            do_reset;
            en_set(4'(g), 8'h04);
            chk("enables", 22'h04, 22'(en_rdata));
            periph_irq[g * 8 + 2 + g % 2] = 1'b1;
            cyc(1);
            periph_irq = '0;
            cyc(2);
            chk("line", 22'(g % 2 == 0 && g * 8 + 2 < 43) << g, 22'(cpu_irq_line));
        end
    endtask
    task automatic wait_vec(input logic [6:0] s, input logic [21:0] v);
        for (int n = 0; n < 40 && vec_valid !== 1'b1; n++) cyc(1);
        chk("valid", 22'h1, 22'(vec_valid));
        chk("slot", 22'(s), 22'(vec_slot));
        chk("vector", v, vec_out);
        cyc(1);
    endtask
    // two pending slots in one group served lowest first
    task automatic t_vector;
        do_reset;
        vec_wr = 1'b1;
        vec_addr = 7'h08;
        vec_wdata = 22'h12_3450;
        cyc(1);
        vec_addr = 7'h09;
        vec_wdata = 22'h2a_bcd1;
        cyc(1);
        vec_wr = 1'b0;
        vec_rd = 1'b1;
        cyc(1);
        vec_rd = 1'b0;
        cyc(1);
        chk("readback", 22'h2a_bcd1, vec_rdata);
        en_set(4'h1, 8'h03);
        periph_irq[9:8] = 2'b11;
        cyc(1);
        periph_irq = '0;
        auto_ack = 1'b1;
        wait_vec(7'h08, 22'h12_3450);
        wait_vec(7'h09, 22'h2a_bcd1);
        auto_ack = 1'b0;
        chk("line idle", 22'h0, 22'(cpu_irq_line));
    endtask
    // every edge mode on a moving pin, disabled channel beside it
    task automatic t_ext;
        for (int m = 0; m < 4; m++) begin
            do_reset;
            ext1_pin_sel = 5'(7 + m * 5);
            ext2_pin_sel = ext1_pin_sel;
            ext1_edge_mode = 2'(m);
            ext2_edge_mode = 2'b11;
            ext1_en = 1'b1;
            en_set(4'h0, 8'h18);
            cyc(5);
            gpio_port_a[ext1_pin_sel] = 1'b1;
            cyc(4);
            chk("stamp rise", 22'(m != 0), 22'(ext1_stamp < 16'h0005));
            chk("stamp off", 22'h1, 22'(ext2_stamp < 16'h0005));
            chk("pending", 22'(m != 0) << 3, 22'(pend_rdata));
            cyc(5);
            gpio_port_a = '0;
            cyc(4);
            chk("stamp fall", 22'(m != 1), 22'(ext1_stamp < 16'h0005));
        end
    endtask
    // nmi-capable channel to either destination, then acknowledged
    task automatic t_nmi;
        for (int r = 0; r < 2; r++) begin
            do_reset;
            nmi_route_nmi = 1'(r);
            nmi_pin_sel = 5'h1f;
            nmi_edge_mode = 2'b01;
            nmi_chan_en = 1'b1;
            cyc(3);
            gpio_port_a[31] = 1'b1;
            cyc(4);
            chk("nmi", 22'(r), 22'(cpu_nmi));
            chk("line13", 22'(1 - r), 22'(cpu_irq_line_thirteenth));
            chk("nmi stamp", 22'h1, 22'(nmi_stamp < 16'h0005));
            auto_ack = 1'b1;
            cyc(3);
            chk("cleared", 22'h0, 22'({cpu_nmi, cpu_irq_line_thirteenth}));
            auto_ack = 1'b0;
            gpio_port_a = '0;
        end
    endtask
    initial begin
        t_lines;
        t_vector;
        t_ext;
        t_nmi;
        stop_test;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        fails++;
        stop_test;
    end
endmodule
`default_nettype wire
